// [logic/pdms_stage.sv]
// pwm output stage: dead-time insertion per pair, mask override per channel
// assumes: ahb-lite slave on hclk, generator inputs and guard synchronous to hclk

// Behaviour
// - enabled pair: each signal's rising edge is delayed by the dead time
// - disabled pair: both signals pass through with no inserted delay
// - pair enable bit acts only while that pair is complementary
// - 9-bit count, msb in enable register bit 4; delay is count plus 1 clocks
// - count applies only in complementary mode with the pair enable set
// - writes to enable and count registers need the timed write guard
// - mask enable 0 routes generator signal, 1 substitutes the mask level
// - masked channel drives its mask level bit: 0 low, 1 high
// - after reset enable, mask enable and mask value read all zeros
module pdms_stage (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timed_write_guard,
  input wire logic [pdms_pkg::PDMS_PAIRS-1:0] pair_complementary,
  input wire logic [pdms_pkg::PDMS_CHANNELS-1:0] gen_pwm,
  output logic [pdms_pkg::PDMS_CHANNELS-1:0] pwm_out
);
  import pdms_pkg::*;

  logic [PDMS_PAIRS-1:0] deadtime_pair_on;
  logic [PDMS_COUNT_W-1:0] deadtime_count;
  logic [PDMS_CHANNELS-1:0] channel_mask_on;
  logic [PDMS_CHANNELS-1:0] channel_mask_level;
  logic [PDMS_PAIRS-1:0] next_deadtime_pair_on;
  logic [PDMS_COUNT_W-1:0] next_deadtime_count;
  logic [PDMS_CHANNELS-1:0] next_channel_mask_on;
  logic [PDMS_CHANNELS-1:0] next_channel_mask_level;
  logic dp_write;
  logic [7:0] dp_idx;
  logic ap_take;
  logic ap_mapped;
  logic [7:0] ap_idx;
  logic [PDMS_CHANNELS-1:0] dt_active_ch;
  logic [PDMS_CHANNELS-1:0] dly_done;
  logic [PDMS_CHANNELS-1:0] dt_shaped;
  logic [31:0] next_rdata;

  // bus handshake: stalls while the clock enable is low
  assign hreadyout = hce;
  assign hresp = 1'b0;

  assign ap_take = hsel && htrans[1] && hready;
  assign ap_mapped = (haddr[31:PDMS_IDX_MSB+1] == '0) && (haddr[PDMS_IDX_LSB-1:0] == '0) &&
                     (hsize == PDMS_HSIZE_WORD);
  assign ap_idx = haddr[PDMS_IDX_MSB:PDMS_IDX_LSB];

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_idx <= 8'h00;
    end else if (hce) begin
      dp_write <= ap_take && hwrite && ap_mapped;
      dp_idx <= ap_idx;
    end
  end

  // write data phase, guarded registers need the timed write guard
  always_comb begin
    next_deadtime_pair_on = deadtime_pair_on;
    next_deadtime_count = deadtime_count;
    next_channel_mask_on = channel_mask_on;
    next_channel_mask_level = channel_mask_level;
    if (dp_write && timed_write_guard && dp_idx == PDMS_IDX_PAIR_ENABLE) begin
      next_deadtime_pair_on = hwdata[PDMS_PAIR_ON_LSB +: PDMS_PAIRS];
      next_deadtime_count[PDMS_COUNT_W-1] = hwdata[PDMS_COUNT_MSB_BIT];
    end
    if (dp_write && timed_write_guard && dp_idx == PDMS_IDX_COUNT_LOW) begin
      next_deadtime_count[PDMS_COUNT_W-2:0] = hwdata[PDMS_COUNT_W-2:0];
    end
    if (dp_write && dp_idx == PDMS_IDX_MASK_ENABLE) begin
      next_channel_mask_on = hwdata[PDMS_CHANNELS-1:0];
    end
    if (dp_write && dp_idx == PDMS_IDX_MASK_VALUE) begin
      next_channel_mask_level = hwdata[PDMS_CHANNELS-1:0];
    end
  end

  // register storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deadtime_pair_on <= PDMS_PAIR_ENABLE_RST;
      deadtime_count <= PDMS_COUNT_RST;
      channel_mask_on <= PDMS_MASK_ENABLE_RST;
      channel_mask_level <= PDMS_MASK_VALUE_RST;
    end else if (hce) begin
      deadtime_pair_on <= next_deadtime_pair_on;
      deadtime_count <= next_deadtime_count;
      channel_mask_on <= next_channel_mask_on;
      channel_mask_level <= next_channel_mask_level;
    end
  end

  // read mux from the next values, so a write just before a read is seen
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (ap_idx)
      PDMS_IDX_PAIR_ENABLE: begin
        next_rdata[PDMS_PAIR_ON_LSB +: PDMS_PAIRS] = next_deadtime_pair_on;
        next_rdata[PDMS_COUNT_MSB_BIT] = next_deadtime_count[PDMS_COUNT_W-1];
      end
      PDMS_IDX_COUNT_LOW: begin
        next_rdata[PDMS_COUNT_W-2:0] = next_deadtime_count[PDMS_COUNT_W-2:0];
      end
      PDMS_IDX_MASK_ENABLE: begin
        next_rdata[PDMS_CHANNELS-1:0] = next_channel_mask_on;
      end
      PDMS_IDX_MASK_VALUE: begin
        next_rdata[PDMS_CHANNELS-1:0] = next_channel_mask_level;
      end
      PDMS_IDX_STAGE_STATUS: begin
        next_rdata[PDMS_STATUS_OUT_LSB +: PDMS_CHANNELS] = pwm_out;
        next_rdata[PDMS_STATUS_ACTIVE_LSB +: PDMS_CHANNELS] = dt_active_ch;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
    if (!ap_mapped) begin
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hce && ap_take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // per-channel dead-time shaping
  for (genvar c = 0; c < PDMS_CHANNELS; c++) begin : g_ch
    logic [PDMS_DELAY_W-1:0] dly;
    // enable bit only counts in complementary mode
    assign dt_active_ch[c] = deadtime_pair_on[c/2] && pair_complementary[c/2];
    assign dly_done[c] = dly > {1'b0, deadtime_count};
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dly <= '0;
      end else if (hce) begin
        if (!gen_pwm[c]) begin
          dly <= '0;
        end else if (!dly_done[c]) begin
          dly <= dly + 10'h001;
        end
      end
    end
    // rising edge held back, falling edge passes at once
    assign dt_shaped[c] = dt_active_ch[c] ? (gen_pwm[c] && dly_done[c]) : gen_pwm[c];
  end

  // mask after dead time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_out <= '0;
    end else if (hce) begin
      pwm_out <= (channel_mask_on & channel_mask_level) | (~channel_mask_on & dt_shaped);
    end
  end

  // checks
  logic any_write_seen;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      any_write_seen <= 1'b0;
    end else if (hce && dp_write) begin
      any_write_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_mask_level_out: assert property (
    $past(hce) |-> ((pwm_out ^ $past(channel_mask_level)) & $past(channel_mask_on)) == '0)
    else $error("masked channel not at its mask level");

  a_mask_after_dt: assert property (
    $past(hce) && $past(channel_mask_on[0]) && $past(dt_active_ch[0]) && $past(gen_pwm[0]) &&
    !$past(dly_done[0]) && $past(channel_mask_level[0]) |-> pwm_out[0])
    else $error("mask level held back by dead time");

  a_plain_pass_through: assert property (
    $past(hce) |-> ((pwm_out ^ $past(gen_pwm)) & ~$past(channel_mask_on) & ~$past(dt_active_ch)) == '0)
    else $error("unmasked channel without dead time does not follow generator");

  a_mode_gate_pair: assert property (
    $past(hce) && !$past(pair_complementary[1]) && !$past(channel_mask_on[2]) |->
    pwm_out[2] == $past(gen_pwm[2]))
    else $error("dead time applied outside complementary mode");

  a_fall_immediate_dt: assert property (
    hce && dt_active_ch[1] && !channel_mask_on[1] && $fell(gen_pwm[1]) |=> !pwm_out[1])
    else $error("falling edge delayed on dead-time channel");

  a_rise_after_count: assert property (
    $past(hce) && $rose(pwm_out[0]) && !$past(channel_mask_on[0]) && $past(dt_active_ch[0]) |->
    $past(g_ch[0].dly) == ({1'b0, $past(deadtime_count)} + 10'h001))
    else $error("dead time is not count plus one clocks");

  a_zero_count_delay: assert property (
    hce && deadtime_count == '0 && dt_active_ch[3] && !channel_mask_on[3] && $rose(gen_pwm[3]) ##1
    (hce && gen_pwm[3] && dt_active_ch[3] && !channel_mask_on[3] && deadtime_count == '0)[*2]
    |-> !$past(pwm_out[3], 2) && pwm_out[3])
    else $error("single clock dead time not inserted");

  a_guard_blocks_write: assert property (
    hce && dp_write && !timed_write_guard &&
    (dp_idx == PDMS_IDX_PAIR_ENABLE || dp_idx == PDMS_IDX_COUNT_LOW) |=>
    $stable(deadtime_pair_on) && $stable(deadtime_count))
    else $error("unguarded write altered dead-time registers");

  a_guard_allows_write: assert property (
    hce && dp_write && timed_write_guard && dp_idx == PDMS_IDX_COUNT_LOW |=>
    deadtime_count[PDMS_COUNT_W-2:0] == $past(hwdata[PDMS_COUNT_W-2:0]))
    else $error("guarded count write lost");

  a_reset_zero_regs: assert property (
    !any_write_seen |-> deadtime_pair_on == '0 && channel_mask_on == '0 && channel_mask_level == '0)
    else $error("registers not zero after reset");

  c_masked_high: cover property (hce && channel_mask_on[5] && channel_mask_level[5] ##1 pwm_out[5]);
  c_dt_rise: cover property ($rose(pwm_out[0]) && dt_active_ch[0] && deadtime_count > 9'h002);
  c_guard_refused: cover property (hce && dp_write && !timed_write_guard && dp_idx == PDMS_IDX_COUNT_LOW);
  c_status_read: cover property (hce && ap_take && !hwrite && ap_idx == PDMS_IDX_STAGE_STATUS);

endmodule // pdms_stage

// [shared/pdms_pkg.sv]
// constants of the pwm dead-time and mask output stage
// assumes: 32-bit ahb-lite register bus, one 250 mhz system clock
package pdms_pkg;

  // channel and pair counts
  localparam int PDMS_CHANNELS = 6;
  localparam int PDMS_PAIRS = 3;

  // system clock
  localparam int PDMS_CLK_PERIOD_NS = 4;
  localparam int PDMS_SYSTEM_CLOCK_FREQ_MHZ = 1000 / PDMS_CLK_PERIOD_NS;

  // register indexes; byte address is four times the index
  localparam logic [7:0] PDMS_IDX_PAIR_ENABLE = 8'hF9;
  localparam logic [7:0] PDMS_IDX_COUNT_LOW = 8'hFA;
  localparam logic [7:0] PDMS_IDX_MASK_ENABLE = 8'hFB;
  localparam logic [7:0] PDMS_IDX_MASK_VALUE = 8'hFC;
  localparam logic [7:0] PDMS_IDX_STAGE_STATUS = 8'hF0;

  // bus decode
  localparam int PDMS_IDX_LSB = 2;
  localparam int PDMS_IDX_MSB = 9;
  localparam logic [2:0] PDMS_HSIZE_WORD = 3'h2;

  // field positions
  localparam int PDMS_PAIR_ON_LSB = 0;
  localparam int PDMS_COUNT_MSB_BIT = 4;
  localparam int PDMS_COUNT_W = 9;
  localparam int PDMS_DELAY_W = 10;
  localparam int PDMS_STATUS_OUT_LSB = 0;
  localparam int PDMS_STATUS_ACTIVE_LSB = 8;

  // reset values
  localparam logic [2:0] PDMS_PAIR_ENABLE_RST = 3'h0;
  localparam logic [8:0] PDMS_COUNT_RST = 9'h000;
  localparam logic [5:0] PDMS_MASK_ENABLE_RST = 6'h00;
  localparam logic [5:0] PDMS_MASK_VALUE_RST = 6'h00;

endpackage : pdms_pkg

// [tb/pdms_power_stage.sv]
// model of the external power stage driven by the pwm pins
// assumes: pins are levels synchronous to the system clock, channel c in pair c/2
module pdms_power_stage (
  input wire logic [pdms_pkg::PDMS_CHANNELS-1:0] pwm_out,
  output logic [pdms_pkg::PDMS_PAIRS-1:0] overlap
);
  timeunit 1ns;
  timeprecision 100ps;
  import pdms_pkg::*;
  // both switches of a leg on at once
  always_comb begin
    for (int p = 0; p < PDMS_PAIRS; p++) begin
      overlap[p] = pwm_out[2*p] & pwm_out[2*p+1];
    end
  end
endmodule // pdms_power_stage

// [tb/testbench.sv]
// self-checking bench of the pwm dead-time and mask stage
// assumes: pdms_pkg, pdms_stage and the power stage model are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pdms_pkg::*;
  logic hclk = 0, hresetn = 0, hce = 1, hsel = 1, hwrite = 0, guard = 0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, comp = 3'h0, overlap;
  logic [5:0] gen = 6'h00, pwm_out;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  always #2 hclk = ~hclk;
  pdms_stage u_dut (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .timed_write_guard(guard), .pair_complementary(comp), .gen_pwm(gen), .pwm_out(pwm_out));
  pdms_power_stage u_load (.pwm_out(pwm_out), .overlap(overlap));
  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_dly(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      mismatches++;
      $display("Error at %0t: delay %0d clocks, expected %0d", $time, got, exp);
    end
  endtask
  // one ahb-lite single write; g is the guard level in the data phase
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic g);
    @(posedge hclk);
    htrans <= 2'h2; haddr <= a; hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d; guard <= g;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    guard <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2; haddr <= a; hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  // clocks from raising a generator channel to its output rising
  task automatic meas(input int ch, output int n);
    @(posedge hclk);
    gen[ch] <= 1'b1;
    n = 0;
    do begin
      @(posedge hclk);
      #1 n++;
    end while (pwm_out[ch] !== 1'b1 && n < 600);
    chk_val(32'(overlap), 32'h0);
    gen[ch] <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    rd(ad(PDMS_IDX_PAIR_ENABLE), d);
    chk_val(d, 32'h0);
    rd(ad(PDMS_IDX_MASK_ENABLE), d);
    chk_val(d, 32'h0);
    rd(ad(PDMS_IDX_MASK_VALUE), d);
    chk_val(d, 32'h0);
    rd(32'h100, d); chk_val(d, 32'h0);
  endtask
  task automatic t_guard();
    logic [31:0] d;
    wr(ad(PDMS_IDX_PAIR_ENABLE), 32'h17, 1'b0);
    rd(ad(PDMS_IDX_PAIR_ENABLE), d);
    chk_val(d, 32'h0);
    wr(ad(PDMS_IDX_COUNT_LOW), 32'h55, 1'b0);
    rd(ad(PDMS_IDX_COUNT_LOW), d);
    chk_val(d, 32'h0);
    wr(ad(PDMS_IDX_COUNT_LOW), 32'h55, 1'b1);
    rd(ad(PDMS_IDX_COUNT_LOW), d);
    chk_val(d, 32'h55);
    wr(ad(PDMS_IDX_PAIR_ENABLE), 32'h17, 1'b1);
    rd(ad(PDMS_IDX_PAIR_ENABLE), d);
    chk_val(d, 32'h17);
    wr(ad(PDMS_IDX_PAIR_ENABLE), 32'h0, 1'b1);
  endtask
  task automatic t_pass();
    int n;
    comp <= 3'h7;
    for (int c = 0; c < 6; c++) begin
      meas(c, n);
      chk_dly(n, 1);
    end
  endtask
  // count changed only while the generator is idle
  task automatic t_dead();
    int n;
    logic [31:0] d;
    wr(ad(PDMS_IDX_COUNT_LOW), 32'h3, 1'b1);
    for (int p = 0; p < 3; p++) begin
      wr(ad(PDMS_IDX_PAIR_ENABLE), 32'(1 << p), 1'b1);
      meas(2*p, n);
      chk_dly(n, 5);
      meas(2*p+1, n);
      chk_dly(n, 5);
      comp <= 3'h7 & ~3'(1 << p);
      meas(2*p, n);
      chk_dly(n, 1);
      comp <= 3'h7;
    end
    wr(ad(PDMS_IDX_COUNT_LOW), 32'h1, 1'b1);
    wr(ad(PDMS_IDX_PAIR_ENABLE), 32'h11, 1'b1);
    rd(ad(PDMS_IDX_STAGE_STATUS), d);
    chk_val(d, 32'h300);
    meas(0, n);
    chk_dly(n, 259);
  endtask
  task automatic t_mask();
    wr(ad(PDMS_IDX_MASK_VALUE), 32'h15, 1'b0);
    wr(ad(PDMS_IDX_MASK_ENABLE), 32'h3F, 1'b0);
    gen <= 6'h3F;
    repeat (2) @(posedge hclk);
    #1 chk_val(32'(pwm_out), 32'h15);
    wr(ad(PDMS_IDX_MASK_ENABLE), 32'h30, 1'b0);
    repeat (2) @(posedge hclk);
    #1 chk_val(32'(pwm_out), 32'h1C);
    @(posedge hclk);
    hce <= 1'b0;
    gen <= 6'h00;
    repeat (2) @(posedge hclk);
    #1 chk_val(32'(pwm_out), 32'h1C);
    chk_val(32'(hreadyout), 32'h0);
    @(posedge hclk);
    hce <= 1'b1;
    wr(ad(PDMS_IDX_MASK_ENABLE), 32'h0, 1'b0);
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_guard();
    t_pass();
    t_dead();
    t_mask();
    print_verdict();
  end
endmodule // testbench
